// >>> pkg/debug_tap_map.vh
`ifndef DEBUG_TAP_MAP_VH
`define DEBUG_TAP_MAP_VH
`define TAP_ST_W 4
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SH_DR 4'h4
`define TAP_EX1_DR 4'h5
`define TAP_PA_DR 4'h6
`define TAP_EX2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'ha
`define TAP_SH_IR 4'hb
`define TAP_EX1_IR 4'hc
`define TAP_PA_IR 4'hd
`define TAP_EX2_IR 4'he
`define TAP_UPD_IR 4'hf
`define IR_W 5
`define IR_CAPTURE 5'h01
`define IR_IMPCODE 5'h03
`define IR_DEBUG_REQ 5'h04
`define IR_RESET_VAL 5'h1f
`define IMP_SUPPORT_POS 24
`endif

// >>> rtl/edge_sync.v
`timescale 1ns/1ps
// two-flop synchroniser plus a delayed copy for edge finding
module edge_sync (
  input wire sys_clk,
  input wire rst_n,
  input wire din,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  // meta_r feeds only sync_r
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule

// >>> rtl/debug_tap_port.v
`timescale 1ns/1ps
`include "debug_tap_map.vh"
// tap pins sampled on sys_clk; tck is a slow pin clock, edges found by oversampling
// limitation: tck must stay well below a quarter of sys_clk, since every pin
// passes two flops and edges need one more, so a fast tck would be missed
module debug_tap_port #(
  parameter TAP_PRESENT = 1,
  parameter [31:0] IMP_BASE = 32'h00000000
) (
  input wire sys_clk,
  input wire rst_n,
  input wire tap_reset_n,
  input wire tap_clock_in,
  input wire tap_mode_select_in,
  input wire tap_serial_in,
  output wire tap_serial_out,
  output wire tap_out_float_ind,
  input wire debug_int_supported,
  input wire debug_int_request,
  input wire debug_enter,
  input wire debug_exit,
  output wire debug_mode_active,
  output wire debug_int_pending,
  output wire debug_int_support_bit
);
  wire trst_lvl;
  wire tck_rise;
  wire tck_fall;
  wire tms_lvl;
  wire tdi_lvl;
  wire dint_lvl;
  wire dint_rise;

  reg [`TAP_ST_W-1:0] st_r;
  reg [`TAP_ST_W-1:0] st_nxt;
  reg [`IR_W-1:0] ir_r;
  reg [31:0] dr_r;
  reg tdo_r;
  reg float_r;
  reg dm_r;
  reg pend_r;
  reg sup_r;
  reg tap_req_r;

  reg sup_meta_r;
  wire tap_hold;

  // tap reset pin: only its level matters, it holds the controller
  edge_sync u_trst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(tap_reset_n),
    .level(trst_lvl),
    .rise(),
    .fall()
  );
  // tck: only its edges are used, the level is never read
  edge_sync u_tck (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(tap_clock_in),
    .level(),
    .rise(tck_rise),
    .fall(tck_fall)
  );
  // tms at the same depth as tck, so it is settled when a rise is seen
  edge_sync u_tms (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(tap_mode_select_in),
    .level(tms_lvl),
    .rise(),
    .fall()
  );
  // tdi at the same depth as tck
  edge_sync u_tdi (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(tap_serial_in),
    .level(tdi_lvl),
    .rise(),
    .fall()
  );
  // cpu-clock sampled request: high now, low last period
  edge_sync u_dint (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(debug_int_request),
    .level(dint_lvl),
    .rise(dint_rise),
    .fall()
  );

  // shift states are the only ones in which the data pin is driven;
  // every other state leaves the pin floating for other devices
  function is_shift;
    input [`TAP_ST_W-1:0] st;
    begin
      is_shift = (st == `TAP_SH_IR) || (st == `TAP_SH_DR);
    end
  endfunction

  // controller held while test reset is low, or for good when absent
  assign tap_hold = !trst_lvl || (TAP_PRESENT == 0);

  // standard tap state walk driven by tms on each tck rise
  // unknown codes fall back to reset rather than hang the walk
  always @* begin
    case (st_r)
      `TAP_RESET: st_nxt = tms_lvl ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: st_nxt = tms_lvl ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: st_nxt = tms_lvl ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: st_nxt = tms_lvl ? `TAP_EX1_DR : `TAP_SH_DR;
      `TAP_SH_DR: st_nxt = tms_lvl ? `TAP_EX1_DR : `TAP_SH_DR;
      `TAP_EX1_DR: st_nxt = tms_lvl ? `TAP_UPD_DR : `TAP_PA_DR;
      `TAP_PA_DR: st_nxt = tms_lvl ? `TAP_EX2_DR : `TAP_PA_DR;
      `TAP_EX2_DR: st_nxt = tms_lvl ? `TAP_UPD_DR : `TAP_SH_DR;
      `TAP_UPD_DR: st_nxt = tms_lvl ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: st_nxt = tms_lvl ? `TAP_RESET : `TAP_CAP_IR;
      `TAP_CAP_IR: st_nxt = tms_lvl ? `TAP_EX1_IR : `TAP_SH_IR;
      `TAP_SH_IR: st_nxt = tms_lvl ? `TAP_EX1_IR : `TAP_SH_IR;
      `TAP_EX1_IR: st_nxt = tms_lvl ? `TAP_UPD_IR : `TAP_PA_IR;
      `TAP_PA_IR: st_nxt = tms_lvl ? `TAP_EX2_IR : `TAP_PA_IR;
      `TAP_EX2_IR: st_nxt = tms_lvl ? `TAP_UPD_IR : `TAP_SH_IR;
      `TAP_UPD_IR: st_nxt = tms_lvl ? `TAP_SEL_DR : `TAP_IDLE;
      default: st_nxt = `TAP_RESET;
    endcase
  end

  // tap controller: held in reset by the synchronised tap reset, or absent
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= `TAP_RESET;
      ir_r <= `IR_RESET_VAL;
      dr_r <= 32'h00000000;
      tap_req_r <= 1'b0;
    end else if (tap_hold) begin
      st_r <= `TAP_RESET;
      ir_r <= `IR_RESET_VAL;
      dr_r <= 32'h00000000;
      tap_req_r <= 1'b0;
    end else begin
      tap_req_r <= 1'b0;
      if (tck_rise) begin
        st_r <= st_nxt;
        // actions keyed on the state being left at this tck rise
        case (st_r)
          `TAP_RESET: ir_r <= `IR_RESET_VAL;
          `TAP_CAP_IR: ir_r <= `IR_CAPTURE;
          `TAP_SH_IR: ir_r <= {tdi_lvl, ir_r[`IR_W-1:1]};
          `TAP_CAP_DR: begin
            if (ir_r == `IR_IMPCODE)
              dr_r <= IMP_BASE | ({31'h00000000, sup_r} << `IMP_SUPPORT_POS);
            else
              dr_r <= 32'h00000000;
          end
          `TAP_SH_DR: dr_r <= {tdi_lvl, dr_r[31:1]};
          `TAP_UPD_DR: tap_req_r <= (ir_r == `IR_DEBUG_REQ) & dr_r[31];
          default: dr_r <= dr_r;
        endcase
      end
    end
  end

  // tdo changes on tck fall; float unless shifting
  // float rises again at the first fall after the walk leaves a shift state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r <= 1'b0;
      float_r <= 1'b1;
    end else if (tap_hold) begin
      tdo_r <= 1'b0;
      float_r <= 1'b1;
    end else if (tck_fall) begin
      tdo_r <= (st_r == `TAP_SH_IR) ? ir_r[0] : dr_r[0];
      float_r <= !is_shift(st_r);
    end
  end

  // static support strap caught after reset release, not in the reset branch
  // it is a pin, so it passes two flops like the others
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_meta_r <= 1'b0;
      sup_r <= 1'b0;
    end else begin
      sup_meta_r <= debug_int_supported;
      sup_r <= sup_meta_r;
    end
  end

  // debug mode flag: entry wins over an exit in the same cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      dm_r <= 1'b0;
    else if (debug_enter)
      dm_r <= 1'b1;
    else if (debug_exit)
      dm_r <= 1'b0;
  end

  // pending request: the clear on entry beats a new edge, so an edge in the
  // entry cycle is dropped instead of being left over for the next exit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      pend_r <= 1'b0;
    else if (dm_r || debug_enter)
      pend_r <= 1'b0;
    else if (sup_r && (dint_rise || tap_req_r))
      pend_r <= 1'b1;
  end

  // outputs straight from flops; the pin buffer itself sits outside the core
  assign tap_serial_out = tdo_r;
  assign tap_out_float_ind = float_r;
  assign debug_mode_active = dm_r;
  assign debug_int_pending = pend_r;
  assign debug_int_support_bit = sup_r;
endmodule

// >>> testbench/dbg_port_sva.sv
`timescale 1ns/1ps
// pin-level checks on the debug request path and float indication
module dbg_port_sva (
  input wire sys_clk,
  input wire rst_n,
  input wire tap_reset_n,
  input wire tap_out_float_ind,
  input wire debug_int_request,
  input wire debug_enter,
  input wire debug_exit,
  input wire debug_mode_active,
  input wire debug_int_pending,
  input wire debug_int_support_bit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_enter_clears: assert property (debug_enter |=> debug_mode_active && !debug_int_pending)
    else $error("enter");
  chk_mode_holds: assert property (debug_mode_active && !debug_exit |=> debug_mode_active)
    else $error("hold");
  chk_mode_exit: assert property (debug_exit && !debug_enter |=> !debug_mode_active)
    else $error("exit");
  chk_ignored_in_debug: assert property (debug_mode_active && !debug_int_pending |=> !debug_int_pending)
    else $error("debug edge");
  chk_level_no_req: assert property ((debug_int_request && !debug_int_pending)[*6] |=> !debug_int_pending)
    else $error("level");
  chk_edge_raises: assert property ($rose(debug_int_request) && debug_int_support_bit
    && !debug_mode_active && !debug_enter |-> ##[1:5] debug_int_pending)
    else $error("edge");
  chk_unsupported_off: assert property (!debug_int_support_bit && !debug_int_pending |=> !debug_int_pending)
    else $error("support");
  chk_tap_reset_float: assert property (!tap_reset_n[*4] |-> tap_out_float_ind)
    else $error("float");
endmodule

// >>> testbench/tap_probe.sv
`timescale 1ns/1ps
// probe: tck stands low between frames, tms and tdi change only while tck is low
module tap_probe (
  output reg tap_clock_in,
  output reg tap_mode_select_in,
  output reg tap_serial_in,
  output reg tap_reset_n,
  input wire tap_serial_out,
  input wire tap_out_float_ind,
  output wire pin
);
  assign pin = tap_out_float_ind ? 1'bz : tap_serial_out; // chip-level buffer
  // test reset held low from power-up until the bench lets go
  initial begin
    tap_clock_in = 1'b0;
    tap_mode_select_in = 1'b1;
    tap_serial_in = 1'b0;
    tap_reset_n = 1'b0;
  end
  // test reset changes on a sys_clk edge like any other bench input
  task set_reset(input v);
    tap_reset_n <= v;
  endtask
  // one 800 ns tck period; tdi toggles so a stale bit never looks valid
  task step(input m);
    tap_mode_select_in = m;
    tap_serial_in = ~tap_serial_in;
    #400 tap_clock_in = 1'b1;
    #400 tap_clock_in = 1'b0;
  endtask
endmodule

// >>> testbench/tb_debug_tap_pins_and_debug_interrupt.sv
`timescale 1ns/1ps
module tb_debug_tap_pins_and_debug_interrupt;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg debug_int_supported = 1'b1;
  reg debug_int_request = 1'b0;
  reg debug_enter = 1'b0;
  reg debug_exit = 1'b0;
  wire tap_clock_in, tap_mode_select_in, tap_serial_in, tap_reset_n, tap_serial_out;
  wire tap_out_float_ind, debug_mode_active, debug_int_pending, debug_int_support_bit, pin;
  integer mismatches = 0;
  integer n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  debug_tap_port DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tap_reset_n(tap_reset_n),
    .tap_clock_in(tap_clock_in),
    .tap_mode_select_in(tap_mode_select_in),
    .tap_serial_in(tap_serial_in),
    .tap_serial_out(tap_serial_out),
    .tap_out_float_ind(tap_out_float_ind),
    .debug_int_supported(debug_int_supported),
    .debug_int_request(debug_int_request),
    .debug_enter(debug_enter),
    .debug_exit(debug_exit),
    .debug_mode_active(debug_mode_active),
    .debug_int_pending(debug_int_pending),
    .debug_int_support_bit(debug_int_support_bit)
  );
  tap_probe probe (
    .tap_clock_in(tap_clock_in),
    .tap_mode_select_in(tap_mode_select_in),
    .tap_serial_in(tap_serial_in),
    .tap_reset_n(tap_reset_n),
    .tap_serial_out(tap_serial_out),
    .tap_out_float_ind(tap_out_float_ind),
    .pin(pin)
  );
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %0s exp %b got %b", name, exp, got);
    end
  endtask
  // request edge, clearing on debug entry, edges ignored inside debug mode
  task t_edge;
    debug_int_request <= 1'b1;
    tick(6);
    chk("pend", 1'b1, debug_int_pending);
    debug_enter <= 1'b1;
    tick(1);
    debug_enter <= 1'b0;
    debug_int_request <= 1'b0;
    @(negedge sys_clk);
    chk("dm", 1'b1, debug_mode_active);
    tick(4);
    chk("pend", 1'b0, debug_int_pending);
    debug_int_request <= 1'b1;
    tick(6);
    chk("pend", 1'b0, debug_int_pending);
    debug_exit <= 1'b1;
    tick(1);
    debug_exit <= 1'b0;
    tick(8);
    chk("dm", 1'b0, debug_mode_active);
    chk("pend", 1'b0, debug_int_pending);
    $display("edge test done");
  endtask
  // strap low: a clean edge must be refused
  task t_unsup;
    debug_int_supported <= 1'b0;
    debug_int_request <= 1'b0;
    tick(4);
    debug_int_request <= 1'b1;
    tick(6);
    chk("sbit", 1'b0, debug_int_support_bit);
    chk("pend", 1'b0, debug_int_pending);
    $display("support test done");
  endtask
  // mid-run reset while in debug mode: mode and pending cleared, strap bit caught again, tdo floating
  task t_reset;
    debug_int_supported <= 1'b1;
    debug_int_request <= 1'b0;
    debug_enter <= 1'b1;
    tick(1);
    debug_enter <= 1'b0;
    tick(4);
    chk("dm", 1'b1, debug_mode_active);
    rst_n <= 1'b0;
    tick(2);
    chk("dm", 1'b0, debug_mode_active);
    rst_n <= 1'b1;
    tick(4);
    chk("pend", 1'b0, debug_int_pending);
    chk("sbit", 1'b1, debug_int_support_bit);
    chk("float", 1'b1, tap_out_float_ind);
    $display("reset test done");
  endtask
  // walk to shift-dr: tdo driven; then test reset floats it again
  task t_tap;
    probe.step(1'b0);
    probe.step(1'b1);
    probe.step(1'b0);
    probe.step(1'b0);
    tick(6);
    chk("float", 1'b0, tap_out_float_ind);
    chk("tdo", 1'b0, tap_serial_out);
    chk("pin", 1'b0, pin);
    probe.set_reset(1'b0);
    tick(6);
    chk("float", 1'b1, tap_out_float_ind);
    chk("pin", 1'bz, pin);
    $display("tap test done");
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(16);
    rst_n <= 1'b1;
    probe.set_reset(1'b1);
    tick(4);
    chk("float", 1'b1, tap_out_float_ind);
    chk("sbit", 1'b1, debug_int_support_bit);
    t_edge;
    t_unsup;
    t_reset;
    t_tap;
    tally_and_finish;
  end
endmodule
bind debug_tap_port dbg_port_sva sva_i (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .tap_reset_n(tap_reset_n),
  .tap_out_float_ind(tap_out_float_ind),
  .debug_int_request(debug_int_request),
  .debug_enter(debug_enter),
  .debug_exit(debug_exit),
  .debug_mode_active(debug_mode_active),
  .debug_int_pending(debug_int_pending),
  .debug_int_support_bit(debug_int_support_bit)
);
